//--- rlc_cfg.svh
`ifndef RLC_CFG_SVH
`define RLC_CFG_SVH

// ------
// register offsets
// ------
`define RLC_OFS_VIDEO_AUX 8'h13
`define RLC_OFS_RX_EQ 8'h20
`define RLC_OFS_UP_EQ 8'h21
`define RLC_OFS_USB_PWR 8'h22
`define RLC_REG_RESET 8'h00

// ------
// field positions
// ------
`define RLC_SNOOP_OFF_BIT 7
`define RLC_ROUTE_HI 5
`define RLC_ROUTE_LO 4
`define RLC_LANE_OFF_HI 3
`define RLC_COMPLIANCE_BIT 7
`define RLC_LOWFREQ_SIGNAL_EQUALIZE_BIT 6
`define RLC_DEBOUNCE_BIT 5
`define RLC_DETECT_OFF_BIT 4
`define RLC_PERIOD_HI 3
`define RLC_PERIOD_LO 2
`define RLC_CM_CTRL_HI 1

// ------
// i2c framing
// ------
`define RLC_I2C_ADDR 7'h2A
`define RLC_BITS_PER_BYTE 4'h8

// ------
// timing
// ------
`define RLC_CLK_MHZ 20
`define RLC_DEBOUNCE_US 200
`define RLC_DEBOUNCE_CYC (`RLC_DEBOUNCE_US * `RLC_CLK_MHZ)
`define RLC_RXDET_SHORT_MS 8
`define RLC_RXDET_LONG_MS 12
`define RLC_RXDET_SHORT_CYC (`RLC_RXDET_SHORT_MS * 1000 * `RLC_CLK_MHZ)
`define RLC_RXDET_LONG_CYC (`RLC_RXDET_LONG_MS * 1000 * `RLC_CLK_MHZ)

`endif

//--- rlc_pkg.sv
package rlc_pkg;
   // i2c slave byte-level states
   typedef enum logic [3:0] {
      RLC_IDLE = 4'h0,
      RLC_ADDR = 4'h1,
      RLC_ADDR_ACK = 4'h2,
      RLC_PTR = 4'h3,
      RLC_PTR_ACK = 4'h4,
      RLC_WDATA = 4'h5,
      RLC_WDATA_ACK = 4'h6,
      RLC_RDATA = 4'h7,
      RLC_RDATA_ACK = 4'h8
   } rlc_state_t;

   // sideband route force codes
   typedef enum logic [1:0] {
      RLC_ROUTE_AUTO = 2'h0,
      RLC_ROUTE_STRAIGHT = 2'h1,
      RLC_ROUTE_CROSSED = 2'h2,
      RLC_ROUTE_OPEN = 2'h3
   } rlc_route_t;
endpackage : rlc_pkg

//--- rlc_lowpower_timer.sv
`timescale 1ns/1ps
`include "rlc_cfg.svh"

module rlc_lowpower_timer #(
   parameter logic [17:0] SHORT_CYC = 18'h27100,
   parameter logic [17:0] LONG_CYC = 18'h3A980
) (
   input wire logic clk, // block clock
   input wire logic rst, // synchronous reset
   input wire logic lowpower, // link in u2/u3
   input wire logic lfps, // lfps seen, already synchronised
   input wire logic debounce_en, // require held lfps before exit
   input wire logic detect_off, // suppress receiver detection in u2/u3
   input wire logic [1:0] period_sel, // detection interval code
   output logic exit_ok, // exit from u2/u3 may proceed
   output logic rxdet_pulse // one-cycle receiver detection strobe
);
   localparam logic [11:0] DEB_CYC = 12'(`RLC_DEBOUNCE_CYC);

   logic [11:0] deb_q;
   logic [11:0] deb_d;
   logic [17:0] per_q;
   logic [17:0] per_d;
   logic exit_q;
   logic pulse_q;

   // debounce counter runs while lfps is held, saturates at the limit
   assign deb_d = !lfps ? 12'h000 : (deb_q == DEB_CYC) ? deb_q : deb_q + 12'h001;

   // interval counter wraps at the selected period; reserved codes act as 8 ms
   wire [17:0] period_w = (period_sel == 2'h1) ? LONG_CYC : SHORT_CYC; // [RULE_17]
   wire period_end_w = (per_q >= period_w - 18'h00001);
   assign per_d = period_end_w ? 18'h00000 : per_q + 18'h00001;
   wire detect_allow_w = !(lowpower && detect_off); // [RULE_13]
   wire exit_d_w = lowpower && lfps && (!debounce_en || deb_q == DEB_CYC); // [RULE_12]

   // counters and registered outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         deb_q <= 12'h000;
         per_q <= 18'h00000;
         exit_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         deb_q <= deb_d;
         per_q <= per_d;
         exit_q <= exit_d_w;
         pulse_q <= period_end_w && detect_allow_w;
      end
   end

   assign exit_ok = exit_q;
   assign rxdet_pulse = pulse_q;
endmodule : rlc_lowpower_timer

//--- rlc_lane_ctrl_regs.sv
`timescale 1ns/1ps
`include "rlc_cfg.svh"

// Overview of operation
// (RULE_01) video/aux register bit 7 set turns aux snooping off; clear keeps it on
// (RULE_02) route force 00 automatic, 01 n-sbu1 p-sbu2, 10 n-sbu2 p-sbu1, 11 open
// (RULE_03) forced route codes pass aux regardless of control and orientation selects
// (RULE_04) lane off bits act only while snooping is off
// (RULE_05) bits 3..0 disable video lanes 3..0 when set
// (RULE_06) rx equalize fields read the strap values while pin override is clear
// (RULE_07) with pin override set, written rx equalize fields drive the receivers
// (RULE_08) upstream equalize in bits 3:0, strap value when not overridden, 7:4 zero
// (RULE_09) with pin override set, written upstream equalize drives that receiver
// (RULE_10) power register bit 7 shows compliance mode, zero otherwise
// (RULE_11) equalization forced to zero during lfps unless bit 6 is set
// (RULE_12) bit 5 set requires 200 us of lfps before leaving u2/u3
// (RULE_13) bit 4 set suppresses receiver detection in u2/u3
// (RULE_14) all four registers reset to zero
// (RULE_15) pin override selects strap or register equalization
// (RULE_16) snooping on enables lanes from snooped lane count, others off
// (RULE_17) bits 3:2 pick detection interval, 00 is 8 ms, 01 is 12 ms
// (RULE_18) reserved bits read zero and ignore writes
module rlc_lane_ctrl_regs
   import rlc_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = `RLC_I2C_ADDR, // arbitrary bus address
   parameter int unsigned RXDET_SHORT_CYC = `RLC_RXDET_SHORT_CYC, // 8 ms in cycles
   parameter int unsigned RXDET_LONG_CYC = `RLC_RXDET_LONG_CYC // 12 ms in cycles
) (
   input wire logic CLOCK, // 20 MHz block clock
   input wire logic RESET, // synchronous, active high
   input wire logic SCL_IN, // i2c clock pin level
   input wire logic SDA_IN, // i2c data pin level
   output logic SDA_OUT, // i2c data drive value, always low
   output logic SDA_OE, // i2c data drive enable
   input wire logic PIN_OVERRIDE, // general control pin override bit
   input wire logic [3:0] USB_EQUALIZE_STRAP_FIRST, // sampled strap, first receiver
   input wire logic [3:0] USB_EQUALIZE_STRAP_SECOND, // sampled strap, second receiver
   input wire logic [3:0] UPSTREAM_EQUALIZE_STRAP, // sampled strap, upstream receiver
   input wire logic [4:0] SNOOP_LANE_COUNT, // snooped lane count value
   input wire logic VIDEO_CONTROL_SELECT, // video path selected
   input wire logic ORIENTATION_SELECT, // plug flipped
   input wire logic COMPLIANCE_ACTIVE, // usb compliance mode from link logic
   input wire logic LOWPOWER_STATE, // usb link in u2/u3
   input wire logic LFPS_DETECT, // analog lfps detector, asynchronous
   output logic AUX_SNOOP_EN, // aux snooping active
   output logic [3:0] VIDEO_LANE_EN, // per-lane video enable
   output logic AUXN_SBU1_EN, // aux n to sbu1 switch
   output logic AUXP_SBU2_EN, // aux p to sbu2 switch
   output logic AUXN_SBU2_EN, // aux n to sbu2 switch
   output logic AUXP_SBU1_EN, // aux p to sbu1 switch
   output logic [3:0] RX_FIRST_EQUALIZE, // applied equalize, first receiver
   output logic [3:0] RX_SECOND_EQUALIZE, // applied equalize, second receiver
   output logic [3:0] UPSTREAM_EQUALIZE, // applied equalize, upstream receiver
   output logic [1:0] COMPLIANCE_CTRL, // compliance control field
   output logic LOWPOWER_EXIT_OK, // u2/u3 exit may proceed
   output logic RXDET_STROBE // receiver detection strobe
);
   // ------
   // helpers
   // ------
   // lanes in use for a snooped lane count
   function automatic logic [3:0] lanes_for_count(input logic [4:0] cnt);
      logic [3:0] en;
      en = 4'h0;
      if (cnt == 5'h01) begin
         en = 4'h1;
      end else if (cnt == 5'h02) begin
         en = 4'h3;
      end else if (cnt == 5'h04) begin
         en = 4'hF;
      end
      return en;
   endfunction : lanes_for_count

   // strap or register by pin override
   function automatic logic [3:0] pick_eq(input logic ovr, input logic [3:0] reg_v, input logic [3:0] strap);
      return ovr ? reg_v : strap;
   endfunction : pick_eq

   // ------
   // pin synchronisers
   // ------
   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   logic lfps_m_q;
   logic lfps_s_q;

   // two flops per pin, then one history flop on the synchronised scl and sda levels
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
         lfps_m_q <= 1'b0;
         lfps_s_q <= 1'b0;
      end else begin
         scl_m_q <= SCL_IN;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= SDA_IN;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
         lfps_m_q <= LFPS_DETECT;
         lfps_s_q <= lfps_m_q;
      end
   end

   // bus events
   wire start_w = scl_s_q && sda_p_q && !sda_s_q;
   wire stop_w = scl_s_q && !sda_p_q && sda_s_q;
   wire scl_rise_w = scl_s_q && !scl_p_q;
   wire scl_fall_w = !scl_s_q && scl_p_q;

   // ------
   // registers
   // ------
   logic [7:0] vid_q;
   logic [7:0] rxeq_q;
   logic [3:0] upeq_q;
   logic [6:0] pwr_q;
   logic cm_q;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic oe_q;
   logic oe_d;
   rlc_state_t state_q;
   rlc_state_t state_d;

   // field views
   wire snoop_off_w = vid_q[`RLC_SNOOP_OFF_BIT];
   wire [1:0] route_w = vid_q[`RLC_ROUTE_HI:`RLC_ROUTE_LO];
   wire [3:0] lane_off_w = vid_q[`RLC_LANE_OFF_HI:0];
   wire lowfreq_signal_equalize_w = pwr_q[`RLC_LOWFREQ_SIGNAL_EQUALIZE_BIT];
   wire [3:0] eq1_w = pick_eq(PIN_OVERRIDE, rxeq_q[3:0], USB_EQUALIZE_STRAP_FIRST); // [RULE_06] [RULE_15]
   wire [3:0] eq2_w = pick_eq(PIN_OVERRIDE, rxeq_q[7:4], USB_EQUALIZE_STRAP_SECOND); // [RULE_06] [RULE_15]
   wire [3:0] equp_w = pick_eq(PIN_OVERRIDE, upeq_q, UPSTREAM_EQUALIZE_STRAP); // [RULE_08] [RULE_15]

   // read data by pointer; unmapped offsets read zero
   wire [7:0] rd_vid_w = {snoop_off_w, 1'b0, route_w, lane_off_w}; // [RULE_18]
   wire [7:0] rd_pwr_w = {cm_q, pwr_q}; // [RULE_10]
   wire [7:0] rd_data_w = (ptr_q == `RLC_OFS_VIDEO_AUX) ? rd_vid_w :
                          (ptr_q == `RLC_OFS_RX_EQ) ? {eq2_w, eq1_w} :
                          (ptr_q == `RLC_OFS_UP_EQ) ? {4'h0, equp_w} : // [RULE_08]
                          (ptr_q == `RLC_OFS_USB_PWR) ? rd_pwr_w : 8'h00;

   // write strobe at the eighth data bit, before the acknowledge
   wire byte_done_w = scl_fall_w && (cnt_q == `RLC_BITS_PER_BYTE);
   wire wr_fire_w = (state_q == RLC_WDATA) && byte_done_w;
   wire addr_hit_w = (shift_q[7:1] == SLAVE_ADDR);

   // register file writes, reserved bits dropped
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         vid_q <= `RLC_REG_RESET; // [RULE_14]
         rxeq_q <= `RLC_REG_RESET; // [RULE_14]
         upeq_q <= 4'h0; // [RULE_14]
         pwr_q <= 7'h00; // [RULE_14]
         cm_q <= 1'b0; // [RULE_14]
      end else begin
         cm_q <= COMPLIANCE_ACTIVE; // [RULE_10]
         if (wr_fire_w && ptr_q == `RLC_OFS_VIDEO_AUX) begin
            vid_q <= shift_q & 8'hBF; // [RULE_18]
         end
         if (wr_fire_w && ptr_q == `RLC_OFS_RX_EQ) begin
            rxeq_q <= shift_q; // [RULE_07]
         end
         if (wr_fire_w && ptr_q == `RLC_OFS_UP_EQ) begin
            upeq_q <= shift_q[3:0]; // [RULE_09] [RULE_18]
         end
         if (wr_fire_w && ptr_q == `RLC_OFS_USB_PWR) begin
            pwr_q <= shift_q[6:0]; // [RULE_18]
         end
      end
   end

   // ------
   // i2c slave sequencing
   // ------
   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      oe_d = oe_q;
      ptr_d = ptr_q;
      if (start_w) begin
         state_d = RLC_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end else if (stop_w) begin
         state_d = RLC_IDLE;
         oe_d = 1'b0;
      end else begin
         unique case (state_q)
            RLC_IDLE: begin
               oe_d = 1'b0;
            end
            RLC_ADDR, RLC_PTR, RLC_WDATA: begin
               if (scl_rise_w) begin
                  shift_d = {shift_q[6:0], sda_s_q};
                  cnt_d = cnt_q + 4'h1;
               end else if (byte_done_w) begin
                  cnt_d = 4'h0;
                  if (state_q == RLC_ADDR && !addr_hit_w) begin
                     state_d = RLC_IDLE;
                  end else begin
                     oe_d = 1'b1;
                     if (state_q == RLC_ADDR) begin
                        state_d = RLC_ADDR_ACK;
                     end else if (state_q == RLC_PTR) begin
                        state_d = RLC_PTR_ACK;
                        ptr_d = shift_q;
                     end else begin
                        state_d = RLC_WDATA_ACK;
                     end
                  end
               end
            end
            RLC_ADDR_ACK: begin
               if (scl_fall_w) begin
                  if (shift_q[0]) begin
                     state_d = RLC_RDATA;
                     shift_d = rd_data_w;
                     oe_d = !rd_data_w[7];
                  end else begin
                     state_d = RLC_PTR;
                     oe_d = 1'b0;
                  end
               end
            end
            RLC_PTR_ACK, RLC_WDATA_ACK: begin
               if (scl_fall_w) begin
                  state_d = RLC_WDATA;
                  oe_d = 1'b0;
                  if (state_q == RLC_WDATA_ACK) begin
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            end
            RLC_RDATA: begin
               if (scl_rise_w) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall_w) begin
                  if (cnt_q == `RLC_BITS_PER_BYTE) begin
                     state_d = RLC_RDATA_ACK;
                     cnt_d = 4'h0;
                     oe_d = 1'b0;
                     ptr_d = ptr_q + 8'h01;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d = !shift_q[6];
                  end
               end
            end
            RLC_RDATA_ACK: begin
               if (scl_rise_w && sda_s_q) begin
                  state_d = RLC_IDLE;
               end else if (scl_fall_w) begin
                  state_d = RLC_RDATA;
                  shift_d = rd_data_w;
                  oe_d = !rd_data_w[7];
               end
            end
            default: begin
               state_d = RLC_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   // slave state registers
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state_q <= RLC_IDLE;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         oe_q <= 1'b0;
         ptr_q <= 8'h00;
      end else begin
         state_q <= state_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         oe_q <= oe_d;
         ptr_q <= ptr_d;
      end
   end

   assign SDA_OUT = 1'b0;
   assign SDA_OE = oe_q;

   // ------
   // lane, sideband and equalize control
   // ------
   // snooped lane count rules while snooping is on, lane off bits otherwise
   wire [3:0] lane_en_w = snoop_off_w ? ~lane_off_w : // [RULE_04] [RULE_05]
                          lanes_for_count(SNOOP_LANE_COUNT); // [RULE_16]

   // forced codes ignore control and orientation selects
   wire auto_w = (route_w == RLC_ROUTE_AUTO) && VIDEO_CONTROL_SELECT; // [RULE_02]
   wire straight_w = (route_w == RLC_ROUTE_STRAIGHT) || (auto_w && !ORIENTATION_SELECT); // [RULE_03]
   wire crossed_w = (route_w == RLC_ROUTE_CROSSED) || (auto_w && ORIENTATION_SELECT); // [RULE_03]

   // zero equalize during lfps unless told to keep it
   wire eq_zero_w = lfps_s_q && !lowfreq_signal_equalize_w; // [RULE_11]

   logic [3:0] lane_en_q;
   logic [3:0] sbu_q;
   logic [3:0] eq1_q;
   logic [3:0] eq2_q;
   logic [3:0] equp_q;

   // registered control outputs
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         lane_en_q <= 4'h0;
         sbu_q <= 4'h0;
         eq1_q <= 4'h0;
         eq2_q <= 4'h0;
         equp_q <= 4'h0;
      end else begin
         lane_en_q <= lane_en_w;
         sbu_q <= {crossed_w, crossed_w, straight_w, straight_w};
         eq1_q <= eq_zero_w ? 4'h0 : eq1_w; // [RULE_07]
         eq2_q <= eq_zero_w ? 4'h0 : eq2_w; // [RULE_07]
         equp_q <= eq_zero_w ? 4'h0 : equp_w; // [RULE_09]
      end
   end

   assign AUX_SNOOP_EN = !snoop_off_w; // [RULE_01]
   assign VIDEO_LANE_EN = lane_en_q;
   assign AUXN_SBU1_EN = sbu_q[0];
   assign AUXP_SBU2_EN = sbu_q[1];
   assign AUXN_SBU2_EN = sbu_q[2];
   assign AUXP_SBU1_EN = sbu_q[3];
   assign RX_FIRST_EQUALIZE = eq1_q;
   assign RX_SECOND_EQUALIZE = eq2_q;
   assign UPSTREAM_EQUALIZE = equp_q;
   assign COMPLIANCE_CTRL = pwr_q[`RLC_CM_CTRL_HI:0];

   // ------
   // low-power exit and receiver detection timing
   // ------
   rlc_lowpower_timer #(
      .SHORT_CYC(18'(RXDET_SHORT_CYC)),
      .LONG_CYC(18'(RXDET_LONG_CYC))
   ) u_timer (
      .clk(CLOCK),
      .rst(RESET),
      .lowpower(LOWPOWER_STATE),
      .lfps(lfps_s_q),
      .debounce_en(pwr_q[`RLC_DEBOUNCE_BIT]), // [RULE_12]
      .detect_off(pwr_q[`RLC_DETECT_OFF_BIT]), // [RULE_13]
      .period_sel(pwr_q[`RLC_PERIOD_HI:`RLC_PERIOD_LO]), // [RULE_17]
      .exit_ok(LOWPOWER_EXIT_OK),
      .rxdet_pulse(RXDET_STROBE)
   );
endmodule : rlc_lane_ctrl_regs

//--- rlc_i2c_host.sv
`timescale 1ns/1ps
`include "rlc_cfg.svh"

module rlc_i2c_host (
   input wire logic clk, // paces the bus
   input wire logic sda, // resolved data line
   output logic scl, // bus clock, idles high
   output logic sda_low // pulls data line low
);
   int hp = 8; // half bit in clocks, raise for a slow host
   logic [6:0] addr = `RLC_I2C_ADDR; // target address, changed only to be refused

   // bus released and clock standing high until a frame starts
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // ------
   // bus primitives
   // ------
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tk

   // data changes mid-low, sampled late in the high phase
   task automatic bit_x(input logic b, output logic s);
      scl = 1'b0;
      tk(hp / 2);
      sda_low = !b;
      tk(hp / 2);
      scl = 1'b1;
      tk(hp);
      s = sda;
   endtask : bit_x

   task automatic start();
      scl = 1'b0;
      tk(hp / 2);
      sda_low = 1'b0;
      tk(hp / 2);
      scl = 1'b1;
      tk(hp / 2);
      sda_low = 1'b1;
      tk(hp / 2);
   endtask : start

   task automatic stop();
      scl = 1'b0;
      tk(hp / 2);
      sda_low = 1'b1;
      tk(hp / 2);
      scl = 1'b1;
      tk(hp / 2);
      sda_low = 1'b0;
      tk(hp);
   endtask : stop

   // byte out, then the acknowledge clock with the line released
   task automatic tx(input logic [7:0] x, inout logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(x[i], s);
      bit_x(1'b1, s);
      nak = nak | s;
   endtask : tx

   task automatic rx(output logic [7:0] x);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         x[i] = s;
      end
      bit_x(1'b1, s);
   endtask : rx

   // ------
   // register transfers
   // ------
   task automatic wr(input logic [7:0] o, input logic [7:0] x, output logic nak);
      nak = 1'b0;
      start();
      tx({addr, 1'b0}, nak);
      tx(o, nak);
      tx(x, nak);
      stop();
   endtask : wr

   task automatic rd(input logic [7:0] o, output logic [7:0] x, output logic nak);
      nak = 1'b0;
      start();
      tx({addr, 1'b0}, nak);
      tx(o, nak);
      start();
      tx({addr, 1'b1}, nak);
      rx(x);
      stop();
   endtask : rd
endmodule : rlc_i2c_host

//--- rlc_lane_ctrl_regs_chk.sv
`timescale 1ns/1ps

module rlc_lane_ctrl_regs_chk #(
   parameter int unsigned RXDET_SHORT_CYC = 40 // short detect interval
) (
   input wire logic CLOCK, // block clock
   input wire logic RESET, // sync reset
   input wire logic PIN_OVERRIDE, // strap or register
   input wire logic [3:0] USB_EQUALIZE_STRAP_FIRST, // strap
   input wire logic [3:0] USB_EQUALIZE_STRAP_SECOND, // strap
   input wire logic [3:0] UPSTREAM_EQUALIZE_STRAP, // strap
   input wire logic [4:0] SNOOP_LANE_COUNT, // lane count
   input wire logic LOWPOWER_STATE, // u2/u3
   input wire logic LFPS_DETECT, // lfps seen
   input wire logic AUX_SNOOP_EN, // snoop on
   input wire logic [3:0] VIDEO_LANE_EN, // lanes
   input wire logic AUXN_SBU1_EN, // straight
   input wire logic AUXP_SBU2_EN, // straight
   input wire logic AUXN_SBU2_EN, // crossed
   input wire logic AUXP_SBU1_EN, // crossed
   input wire logic [3:0] RX_FIRST_EQUALIZE, // applied
   input wire logic [3:0] RX_SECOND_EQUALIZE, // applied
   input wire logic [3:0] UPSTREAM_EQUALIZE, // applied
   input wire logic [1:0] COMPLIANCE_CTRL, // field
   input wire logic LOWPOWER_EXIT_OK, // exit allowed
   input wire logic RXDET_STROBE // detect pulse
);
   logic [4:0] lfps_hist_q; // recent lfps samples
   logic [17:0] gap_q; // cycles since last strobe
   logic seen_q; // a strobe seen since reset

   // lane count decode expected while snooping
   function automatic logic [3:0] dec(input logic [4:0] c);
      case (c)
         5'h01: dec = 4'h1;
         5'h02: dec = 4'h3;
         5'h04: dec = 4'hF;
         default: dec = 4'h0;
      endcase
   endfunction : dec

   // history covers the synchroniser delay
   always_ff @(posedge CLOCK) begin
      lfps_hist_q <= {lfps_hist_q[3:0], LFPS_DETECT};
      gap_q <= RXDET_STROBE ? 18'h00000 : gap_q + 18'h00001;
      seen_q <= !RESET && (seen_q || RXDET_STROBE);
   end

   // ------
   // assertions
   // ------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   rst_vals_a: assert property ($past(RESET) |-> AUX_SNOOP_EN && VIDEO_LANE_EN == 4'h0
      && COMPLIANCE_CTRL == 2'h0 && RX_FIRST_EQUALIZE == 4'h0) else $error("outputs not cleared by reset");
   lanes_snoop_a: assert property (!$past(RESET) && $past(AUX_SNOOP_EN)
      |-> VIDEO_LANE_EN == dec($past(SNOOP_LANE_COUNT))) else $error("lane enables differ from lane count");
   sb_pair_a: assert property (AUXN_SBU1_EN == AUXP_SBU2_EN && AUXN_SBU2_EN == AUXP_SBU1_EN)
      else $error("sideband switch pair split");
   sb_excl_a: assert property (!(AUXN_SBU1_EN && AUXN_SBU2_EN))
      else $error("straight and crossed both closed");
   strap_eq_a: assert property (!$past(RESET) && !$past(PIN_OVERRIDE) && lfps_hist_q == 5'h00
      |-> RX_FIRST_EQUALIZE == $past(USB_EQUALIZE_STRAP_FIRST) && RX_SECOND_EQUALIZE
      == $past(USB_EQUALIZE_STRAP_SECOND) && UPSTREAM_EQUALIZE == $past(UPSTREAM_EQUALIZE_STRAP))
      else $error("equalize not taken from straps");
   exit_cause_a: assert property (LOWPOWER_EXIT_OK |-> $past(LOWPOWER_STATE) && lfps_hist_q != 5'h00)
      else $error("exit allowed without cause");
   strobe_pulse_a: assert property (RXDET_STROBE |=> !RXDET_STROBE)
      else $error("detect strobe longer than one cycle");
   strobe_gap_a: assert property (RXDET_STROBE && seen_q |-> gap_q >= RXDET_SHORT_CYC - 1)
      else $error("detect strobes too close");

   cover property (LOWPOWER_EXIT_OK);
   cover property (RXDET_STROBE && seen_q);
   cover property (!AUX_SNOOP_EN && AUXN_SBU2_EN);
endmodule : rlc_lane_ctrl_regs_chk

bind rlc_lane_ctrl_regs rlc_lane_ctrl_regs_chk #(.RXDET_SHORT_CYC(RXDET_SHORT_CYC)) i_chk (.*);

//--- rlc_lane_ctrl_regs_test.sv
`timescale 1ns/1ps
`include "rlc_cfg.svh"

module rlc_lane_ctrl_regs_test;
   logic clk, rst, ovr, vcs, ori, cma, lpw, lfps, nak;
   logic [4:0] cnt;
   logic [3:0] s1, s2, su;
   logic [7:0] v, d;
   wire scl, sda_low, sda_oe, snoop, n1, p2, n2, p1, exit_ok, strobe;
   wire [1:0] cctl;
   wire [3:0] eq1, eq2, equ, lane_en;
   wire sda = !(sda_low || sda_oe); // pulled up, either side pulls low
   wire [7:0] lanes = {4'h0, lane_en};
   wire [7:0] sb = {4'h0, n1, p2, n2, p1};
   wire [7:0] eqs = {eq2, eq1};
   wire [7:0] equ8 = {4'h0, equ};
   logic [7:0] sbx [4] = '{8'h0C, 8'h0C, 8'h03, 8'h00};
   logic [7:0] stab [4] = '{8'h40, 8'h44, 8'h4C, 8'h50};
   logic [7:0] sexp [4] = '{8'h0C, 8'h08, 8'h0C, 8'h00};
   logic [7:0] ofs [4] = '{8'h13, 8'h20, 8'h21, 8'h22};
   int err_total = 0;
   int cmp_count = 0;

   rlc_i2c_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   rlc_lane_ctrl_regs #(.RXDET_SHORT_CYC(40), .RXDET_LONG_CYC(60)) i_rlc_lane_ctrl_regs (
      .CLOCK(clk), .RESET(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
      .PIN_OVERRIDE(ovr), .USB_EQUALIZE_STRAP_FIRST(s1), .USB_EQUALIZE_STRAP_SECOND(s2),
      .UPSTREAM_EQUALIZE_STRAP(su), .SNOOP_LANE_COUNT(cnt), .VIDEO_CONTROL_SELECT(vcs),
      .ORIENTATION_SELECT(ori), .COMPLIANCE_ACTIVE(cma), .LOWPOWER_STATE(lpw), .LFPS_DETECT(lfps),
      .AUX_SNOOP_EN(snoop), .VIDEO_LANE_EN(lane_en), .AUXN_SBU1_EN(n1), .AUXP_SBU2_EN(p2),
      .AUXN_SBU2_EN(n2), .AUXP_SBU1_EN(p1), .RX_FIRST_EQUALIZE(eq1), .RX_SECOND_EQUALIZE(eq2),
      .UPSTREAM_EQUALIZE(equ), .COMPLIANCE_CTRL(cctl), .LOWPOWER_EXIT_OK(exit_ok), .RXDET_STROBE(strobe));

   // ------
   // checking tasks
   // ------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wc(input logic [7:0] o, input logic [7:0] x);
      i_host.wr(o, x, nak);
      chk({7'h0, nak}, 8'h00);
   endtask : wc

   task automatic rc(input logic [7:0] o, input logic [7:0] x);
      i_host.rd(o, d, nak);
      chk(d, x);
      chk({7'h0, nak}, 8'h00);
   endtask : rc

   // count detect strobes over a window of 480 cycles
   task automatic strobes(input logic [7:0] x, input logic [7:0] exp);
      logic [7:0] n;
      wc(8'h22, x);
      i_host.tk(70);
      n = 8'h00;
      repeat (480) begin
         i_host.tk(1);
         n = n + {7'h0, strobe};
      end
      chk(n, exp);
   endtask : strobes

   task automatic conclude();
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   // clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // watchdog cuts a hang short
   initial begin
      #4000000;
      err_total++;
      conclude();
   end

   // ------
   // tests
   // ------
   initial begin
      {rst, ovr, vcs, ori, cma, lpw, lfps, cnt} = 12'h800;
      {s1, s2, su} = 12'h000;
      i_host.tk(5);
      rst = 1'b0;
      i_host.tk(4);
      for (int r = 0; r < 4; r++) begin
         vcs = (r == 0);
         ori = (r != 0);
         v = {2'b10, 2'(r), 4'(1 << r)};
         wc(8'h13, v);
         rc(8'h13, v);
         chk(lanes, {4'h0, ~v[3:0]});
         chk(sb, sbx[r]);
         chk({7'h0, snoop}, 8'h00);
      end
      wc(8'h13, 8'hFF);
      rc(8'h13, 8'hBF);
      chk(lanes, 8'h00);
      wc(8'h13, 8'h03);
      cnt = 5'h04;
      i_host.tk(3);
      chk(lanes, 8'h0F);
      cnt = 5'h02;
      i_host.tk(3);
      chk(lanes, 8'h03);
      chk({7'h0, snoop}, 8'h01);
      {s1, s2, su} = 12'h5A3;
      i_host.hp = 12;
      wc(8'h20, 8'h7C);
      wc(8'h21, 8'hF9);
      rc(8'h20, 8'hA5);
      rc(8'h21, 8'h03);
      chk(eqs, 8'hA5);
      chk(equ8, 8'h03);
      ovr = 1'b1;
      i_host.hp = 8;
      rc(8'h20, 8'h7C);
      rc(8'h21, 8'h09);
      chk(eqs, 8'h7C);
      chk(equ8, 8'h09);
      lfps = 1'b1;
      i_host.tk(5);
      chk(eqs, 8'h00);
      wc(8'h22, 8'h40);
      chk(eqs, 8'h7C);
      chk(equ8, 8'h09);
      cma = 1'b1;
      wc(8'h22, 8'h03);
      rc(8'h22, 8'h83);
      chk({6'h0, cctl}, 8'h03);
      cma = 1'b0;
      wc(8'h22, 8'hC0);
      rc(8'h22, 8'h40);
      lpw = 1'b1;
      i_host.tk(5);
      chk({7'h0, exit_ok}, 8'h01);
      wc(8'h22, 8'h60);
      lfps = 1'b0;
      i_host.tk(5);
      lfps = 1'b1;
      i_host.tk(3900);
      chk({7'h0, exit_ok}, 8'h00);
      i_host.tk(200);
      chk({7'h0, exit_ok}, 8'h01);
      foreach (stab[i]) strobes(stab[i], sexp[i]);
      wc(8'h30, 8'h5A);
      rc(8'h30, 8'h00);
      i_host.addr = 7'h15;
      i_host.wr(8'h13, 8'h00, nak);
      chk({7'h0, nak}, 8'h01);
      i_host.addr = `RLC_I2C_ADDR;
      rc(8'h13, 8'h03);
      rst = 1'b1;
      i_host.tk(2);
      rst = 1'b0;
      i_host.tk(4);
      foreach (ofs[i]) rc(ofs[i], 8'h00);
      conclude();
   end
endmodule : rlc_lane_ctrl_regs_test
